// ==== src/esx_exec_consts.vh ====
// Constants for the extended stack instruction executor
`ifndef ESX_EXEC_CONSTS_VH
`define ESX_EXEC_CONSTS_VH

// ----------------------------------------
// Opcode prefixes
// ----------------------------------------
`define ESX_OP_MOVE_W1 9'h1D7
`define ESX_OP_MOVE_W2 4'hF
`define ESX_OP_PUSH_LIT 8'hFA
`define ESX_OP_SUB_PTR 8'hE9
`define ESX_SEL_FRAME_RET 2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ESX_DEST_BIT 9
`define ESX_ACCESS_BIT 8
`define ESX_SEL_HI 7
`define ESX_SEL_LO 6

// ----------------------------------------
// Address constants and reset values
// ----------------------------------------
`define ESX_OFFSET_MAX 8'h5F
`define ESX_ACCESS_SPLIT 8'h80
`define ESX_ACCESS_LOW_BANK 4'h0
`define ESX_ACCESS_HIGH_BANK 4'hF
`define ESX_IND0_BASE 12'hFEB
`define ESX_IND1_BASE 12'hFE3
`define ESX_IND2_BASE 12'hFDB
`define ESX_IND_SPAN 12'h005
`define ESX_PTR_RST 12'h000
`define ESX_ZERO_DATA 8'h00

`endif

// ==== src/esx_addr_resolve.v ====
// Effective data address resolver for byte and bit oriented operands
`timescale 1ns/1ps
`default_nettype none
`include "esx_exec_consts.vh"

module esx_addr_resolve #(
	parameter AW = 12
) (
	input wire i_ext_en, // Extended set enabled
	input wire i_access, // Access bit of the instruction
	input wire [7:0] i_operand, // Embedded register operand
	input wire [3:0] i_bank, // Bank select register
	input wire [AW-1:0] i_frame, // Frame pointer
	output reg [AW-1:0] o_addr, // Resolved address
	output reg o_indexed // Operand used as frame offset
);

	always @* begin
		o_indexed = 1'b0;
		if (i_access) begin
			o_addr = {i_bank, i_operand};
		end else if (i_ext_en && (i_operand <= `ESX_OFFSET_MAX)) begin
			// Frame of zero lands on the plain low access locations
			o_addr = i_frame + {{(AW-8){1'b0}}, i_operand};
			o_indexed = 1'b1;
		end else if (i_operand < `ESX_ACCESS_SPLIT) begin
			o_addr = {`ESX_ACCESS_LOW_BANK, i_operand};
		end else begin
			o_addr = {`ESX_ACCESS_HIGH_BANK, i_operand};
		end
	end

endmodule // esx_addr_resolve
`default_nettype wire

// ==== src/esx_exec.v ====
// Extended stack instruction decode and execute block
// Function
// - Indexed-to-indexed move: two words, source then destination, two cycles.
// - Move addresses are frame pointer plus each 7-bit offset, anywhere.
// - Move source on an indirect register yields zero.
// - Move destination on an indirect register suppresses the write.
// - Push literal: one word, one cycle, literal written at frame pointer.
// - Push literal then decrements frame pointer by one.
// - Subtract 6-bit literal from selected pointer 0..2, no flags touched.
// - Select 3 subtracts from frame pointer, returns via stack top, two cycles.
// - Extended enable also switches on indexed literal offset addressing.
// - Disabled: access bit 0 means access bank, 1 means selected bank.
// - Enabled, access 0, operand up to 5Fh: address is frame plus operand.
// - Operands above 5Fh keep ordinary access bank meaning.
// - Frame pointer zero maps offsets onto original low access addresses.
// - Destination bit keeps its meaning in indexed mode.
// - Configuration enable bit defaults to 0, disabling both features.
`timescale 1ns/1ps
`default_nettype none
`include "esx_exec_consts.vh"

module esx_exec #(
	parameter AW = 12,
	parameter PCW = 21
) (
	input wire I_CLK_SYS, // System clock
	input wire I_SYS_RST, // Synchronous reset, active high
	input wire I_EXT_SET_ENABLE, // Extended set configuration bit
	input wire I_INSTR_VALID, // One fetched word this cycle
	input wire [15:0] I_INSTR, // Fetched instruction word
	input wire [3:0] I_BANK_SELECT_REG, // Bank select register
	input wire [7:0] I_MEM_RDATA, // Data memory read data, valid in the read strobe cycle
	input wire [PCW-1:0] I_RETURN_STACK_TOP, // Return stack top
	output reg [AW-1:0] O_MEM_ADDR, // Data memory address
	output reg O_MEM_RD, // Data memory read strobe
	output reg O_MEM_WR, // Data memory write strobe
	output reg [7:0] O_MEM_WDATA, // Data memory write data
	output reg [AW-1:0] O_PTR0, // Indirect pointer 0
	output reg [AW-1:0] O_PTR1, // Indirect pointer 1
	output reg [AW-1:0] O_FRAME_POINTER, // Frame pointer
	output reg O_PC_LOAD, // Program counter load pulse
	output reg [PCW-1:0] O_PC_VALUE, // Program counter load value
	output reg O_BUSY, // Second cycle of a two-cycle instruction
	output reg O_EFF_VALID, // Standard operand resolved
	output reg [AW-1:0] O_EFF_ADDR, // Resolved operand address
	output reg O_EFF_INDEXED, // Operand taken as frame offset
	output reg O_EFF_TO_REG // Result goes back to the register
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_MOVE2 = 3'b010;
	localparam [2:0] S_RET = 3'b100;

	// Indirect register window check, shared by both move ends
	function is_indirect;
		input [AW-1:0] a;
		begin
			is_indirect = ((a >= `ESX_IND0_BASE) && (a < `ESX_IND0_BASE + `ESX_IND_SPAN)) ||
				((a >= `ESX_IND1_BASE) && (a < `ESX_IND1_BASE + `ESX_IND_SPAN)) ||
				((a >= `ESX_IND2_BASE) && (a < `ESX_IND2_BASE + `ESX_IND_SPAN));
		end
	endfunction

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg rd_pend_ff;
	reg src_zero_ff;
	reg [7:0] src_data_ff;
	reg [AW-1:0] nxt_ptr0, nxt_ptr1, nxt_frame, nxt_addr;
	reg nxt_rd, nxt_wr, nxt_pc_load, nxt_busy;
	reg [7:0] nxt_wdata;
	reg [PCW-1:0] nxt_pc;
	reg nxt_src_zero;
	wire [AW-1:0] res_addr;
	wire res_indexed;
	wire [AW-1:0] src_addr;
	wire [AW-1:0] dst_addr;
	wire [AW-1:0] sub_lit;
	wire [7:0] move_data;

	// Only effective while enabled; disabled means plain addressing
	esx_addr_resolve #(
		.AW(AW)
	) u_resolve (
		.i_ext_en(I_EXT_SET_ENABLE),
		.i_access(I_INSTR[`ESX_ACCESS_BIT]),
		.i_operand(I_INSTR[7:0]),
		.i_bank(I_BANK_SELECT_REG),
		.i_frame(O_FRAME_POINTER),
		.o_addr(res_addr),
		.o_indexed(res_indexed)
	);

	assign src_addr = O_FRAME_POINTER + {{(AW-7){1'b0}}, I_INSTR[6:0]};
	assign dst_addr = src_addr;
	assign sub_lit = {{(AW-6){1'b0}}, I_INSTR[5:0]};
	// Read data arrives in the strobe cycle; capture it at that cycle's end
	assign move_data = src_zero_ff ? `ESX_ZERO_DATA : src_data_ff;

	// ----------------------------------------
	// Decode and execute
	// ----------------------------------------
	always @* begin
		nxt_state = state_ff;
		nxt_ptr0 = O_PTR0;
		nxt_ptr1 = O_PTR1;
		nxt_frame = O_FRAME_POINTER;
		nxt_addr = O_MEM_ADDR;
		nxt_rd = 1'b0;
		nxt_wr = 1'b0;
		nxt_wdata = O_MEM_WDATA;
		nxt_pc_load = 1'b0;
		nxt_pc = O_PC_VALUE;
		nxt_busy = 1'b0;
		nxt_src_zero = src_zero_ff;
		case (state_ff)
			S_IDLE: begin
				if (I_INSTR_VALID && I_EXT_SET_ENABLE) begin
					if (I_INSTR[15:7] == `ESX_OP_MOVE_W1) begin
						nxt_state = S_MOVE2;
						nxt_addr = src_addr;
						nxt_src_zero = is_indirect(src_addr);
						nxt_rd = ~is_indirect(src_addr);
						nxt_busy = 1'b1;
					end else if (I_INSTR[15:8] == `ESX_OP_PUSH_LIT) begin
						nxt_addr = O_FRAME_POINTER;
						nxt_wdata = I_INSTR[7:0];
						nxt_wr = 1'b1;
						nxt_frame = O_FRAME_POINTER - {{(AW-1){1'b0}}, 1'b1};
					end else if (I_INSTR[15:8] == `ESX_OP_SUB_PTR) begin
						case (I_INSTR[`ESX_SEL_HI:`ESX_SEL_LO])
							2'h0: nxt_ptr0 = O_PTR0 - sub_lit;
							2'h1: nxt_ptr1 = O_PTR1 - sub_lit;
							2'h2: nxt_frame = O_FRAME_POINTER - sub_lit;
							default: begin
								nxt_frame = O_FRAME_POINTER - sub_lit;
								nxt_pc = I_RETURN_STACK_TOP;
								nxt_pc_load = 1'b1;
								nxt_busy = 1'b1;
								nxt_state = S_RET;
							end
						endcase
					end
				end
			end
			S_MOVE2: begin
				nxt_busy = 1'b1;
				if (I_INSTR_VALID) begin
					nxt_busy = 1'b0;
					nxt_state = S_IDLE;
					if (I_INSTR[15:12] == `ESX_OP_MOVE_W2) begin
						nxt_addr = dst_addr;
						nxt_wdata = move_data;
						nxt_wr = ~is_indirect(dst_addr);
					end
				end
			end
			S_RET: begin
				// Second cycle is a no-operation
				nxt_state = S_IDLE;
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			state_ff <= S_IDLE;
			rd_pend_ff <= 1'b0;
			src_zero_ff <= 1'b0;
			src_data_ff <= `ESX_ZERO_DATA;
			O_MEM_ADDR <= `ESX_PTR_RST;
			O_MEM_RD <= 1'b0;
			O_MEM_WR <= 1'b0;
			O_MEM_WDATA <= `ESX_ZERO_DATA;
			O_PTR0 <= `ESX_PTR_RST;
			O_PTR1 <= `ESX_PTR_RST;
			O_FRAME_POINTER <= `ESX_PTR_RST;
			O_PC_LOAD <= 1'b0;
			O_PC_VALUE <= {PCW{1'b0}};
			O_BUSY <= 1'b0;
			O_EFF_VALID <= 1'b0;
			O_EFF_ADDR <= `ESX_PTR_RST;
			O_EFF_INDEXED <= 1'b0;
			O_EFF_TO_REG <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			rd_pend_ff <= nxt_rd;
			src_zero_ff <= nxt_src_zero;
			if (rd_pend_ff) begin
				src_data_ff <= I_MEM_RDATA;
			end
			O_MEM_ADDR <= nxt_addr;
			O_MEM_RD <= nxt_rd;
			O_MEM_WR <= nxt_wr;
			O_MEM_WDATA <= nxt_wdata;
			O_PTR0 <= nxt_ptr0;
			O_PTR1 <= nxt_ptr1;
			O_FRAME_POINTER <= nxt_frame;
			O_PC_LOAD <= nxt_pc_load;
			O_PC_VALUE <= nxt_pc;
			O_BUSY <= nxt_busy;
			// Standard words only; extended words decoded while enabled are masked out
			O_EFF_VALID <= I_INSTR_VALID && (state_ff == S_IDLE) && !(I_EXT_SET_ENABLE &&
				((I_INSTR[15:7] == `ESX_OP_MOVE_W1) || (I_INSTR[15:8] == `ESX_OP_PUSH_LIT) ||
				(I_INSTR[15:8] == `ESX_OP_SUB_PTR)));
			if (I_INSTR_VALID) begin
				O_EFF_ADDR <= res_addr;
				O_EFF_INDEXED <= res_indexed;
				O_EFF_TO_REG <= I_INSTR[`ESX_DEST_BIT];
			end
		end
	end

endmodule // esx_exec
`default_nettype wire

// ==== sim/esx_exec_monitor.sv ====
// Port checker for the extended stack executor
`timescale 1ns/1ps
`default_nettype none
module esx_exec_monitor #(parameter AW = 12, parameter PCW = 21) (
	input wire I_CLK_SYS, // Clock
	input wire I_SYS_RST, // Reset
	input wire I_EXT_SET_ENABLE, // Mode
	input wire I_INSTR_VALID, // Word strobe
	input wire [15:0] I_INSTR, // Word
	input wire [3:0] I_BANK_SELECT_REG, // Bank
	input wire [PCW-1:0] I_RETURN_STACK_TOP, // Stack top
	input wire [AW-1:0] O_MEM_ADDR, // Address
	input wire O_MEM_WR, // Write
	input wire [7:0] O_MEM_WDATA, // Data
	input wire [AW-1:0] O_PTR0, // Pointer 0
	input wire [AW-1:0] O_FRAME_POINTER, // Frame
	input wire O_PC_LOAD, // Load
	input wire [PCW-1:0] O_PC_VALUE, // Target
	input wire O_BUSY, // Busy
	input wire O_EFF_VALID, // Resolved
	input wire [AW-1:0] O_EFF_ADDR, // Operand address
	input wire O_EFF_INDEXED, // Indexed
	input wire O_EFF_TO_REG // Destination
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);
	wire [AW-1:0] fp = O_FRAME_POINTER;
	wire [15:0] iw = I_INSTR;
	// Busy excludes move word 2 and the return no-op cycle
	wire go = I_INSTR_VALID && I_EXT_SET_ENABLE && !O_BUSY;
	wire lo = go && iw[15:12] < 4'hE && !iw[8];

	property p_push; go && iw[15:8] == 8'hFA |=> O_MEM_WR && O_MEM_WDATA == $past(iw[7:0])
		&& O_MEM_ADDR == $past(fp) && fp == $past(fp) - 1'b1; endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_sub; go && iw[15:6] == 10'h3A4 |=> O_PTR0 == $past(O_PTR0) - $past(iw[5:0]) && $stable(fp); endproperty
	a_sub: assert property (p_sub) else $error("subtract wrong");
	property p_ret; go && iw[15:6] == 10'h3A7 |=> O_PC_LOAD && O_BUSY && O_PC_VALUE == $past(I_RETURN_STACK_TOP)
		&& fp == $past(fp) - $past(iw[5:0]) ##1 !O_PC_LOAD && !O_BUSY; endproperty
	a_ret: assert property (p_ret) else $error("return wrong");
	property p_mv1; go && iw[15:7] == 9'h1D7 |=> O_BUSY && !O_MEM_WR && O_MEM_ADDR == $past(fp) + $past(iw[6:0]); endproperty
	a_mv1: assert property (p_mv1) else $error("move source wrong");
	property p_mv2; I_INSTR_VALID && O_BUSY && !O_PC_LOAD && iw[15:12] == 4'hF
		|=> !O_BUSY && O_MEM_ADDR == $past(fp) + $past(iw[6:0]); endproperty
	a_mv2: assert property (p_mv2) else $error("move target wrong");
	property p_dis; I_INSTR_VALID && !I_EXT_SET_ENABLE && !O_BUSY |=> O_EFF_VALID && !O_EFF_INDEXED
		&& O_EFF_ADDR == {$past(iw[8]) ? $past(I_BANK_SELECT_REG) : {4{$past(iw[7])}}, $past(iw[7:0])}; endproperty
	a_dis: assert property (p_dis) else $error("plain address wrong");
	property p_idx; lo && iw[7:0] <= 8'h5F |=> O_EFF_INDEXED && O_EFF_TO_REG == $past(iw[9])
		&& O_EFF_ADDR == $past(fp) + $past(iw[7:0]); endproperty
	a_idx: assert property (p_idx) else $error("indexed address wrong");
	property p_hi; lo && iw[7:0] > 8'h5F |=> !O_EFF_INDEXED
		&& O_EFF_ADDR == {{4{$past(iw[7])}}, $past(iw[7:0])}; endproperty
	a_hi: assert property (p_hi) else $error("high operand wrong");
endmodule // esx_exec_monitor
bind esx_exec esx_exec_monitor #(.AW(AW), .PCW(PCW)) u_mon (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
	.I_EXT_SET_ENABLE(I_EXT_SET_ENABLE), .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR(I_INSTR),
	.I_BANK_SELECT_REG(I_BANK_SELECT_REG), .I_RETURN_STACK_TOP(I_RETURN_STACK_TOP), .O_MEM_ADDR(O_MEM_ADDR),
	.O_MEM_WR(O_MEM_WR), .O_MEM_WDATA(O_MEM_WDATA), .O_PTR0(O_PTR0), .O_FRAME_POINTER(O_FRAME_POINTER),
	.O_PC_LOAD(O_PC_LOAD), .O_PC_VALUE(O_PC_VALUE), .O_BUSY(O_BUSY), .O_EFF_VALID(O_EFF_VALID),
	.O_EFF_ADDR(O_EFF_ADDR), .O_EFF_INDEXED(O_EFF_INDEXED), .O_EFF_TO_REG(O_EFF_TO_REG));
`default_nettype wire

// ==== sim/esx_exec_tb.sv ====
// Self-checking bench for the extended stack executor
`timescale 1ns/1ps
`default_nettype none
module esx_exec_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ext = 1'b0;
	logic vld = 1'b0;
	logic [15:0] ins = 16'h0000;
	logic [3:0] bank_select_reg = 4'h7;
	logic [7:0] rdat = 8'hEE;
	logic [20:0] return_stack_top = 21'h12345;
	logic [11:0] addr, p0, p1, fp, ea;
	logic [20:0] pcv;
	logic [7:0] wd;
	logic mrd, mwr, pc_low_byte, busy, ev, ei, etr;
	int bad_count = 0;
	int checks = 0;

	esx_exec uut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_EXT_SET_ENABLE(ext), .I_INSTR_VALID(vld),
		.I_INSTR(ins), .I_BANK_SELECT_REG(bank_select_reg), .I_MEM_RDATA(rdat), .I_RETURN_STACK_TOP(return_stack_top),
		.O_MEM_ADDR(addr), .O_MEM_RD(mrd), .O_MEM_WR(mwr), .O_MEM_WDATA(wd), .O_PTR0(p0), .O_PTR1(p1),
		.O_FRAME_POINTER(fp), .O_PC_LOAD(pc_low_byte), .O_PC_VALUE(pcv), .O_BUSY(busy), .O_EFF_VALID(ev),
		.O_EFF_ADDR(ea), .O_EFF_INDEXED(ei), .O_EFF_TO_REG(etr));

	initial forever #5 clk = ~clk;

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// One word per call; returns where its results are visible
	task w(input logic [15:0] v);
		@(negedge clk);
		vld = 1'b1;
		ins = v;
		@(negedge clk);
		vld = 1'b0;
	endtask

	// Gap of two idle cycles lets the read data land before word 2
	task mv(input logic [15:0] a, input logic [15:0] b, input logic [13:0] x1, input logic [21:0] x2);
		w(a);
		chk({busy, mrd, addr}, x1);
		// Memory answers only in the cycle the read strobe is high
		rdat = 8'h33;
		@(negedge clk);
		rdat = 8'hEE;
		w(b);
		chk({busy, mwr, wd, addr}, x2);
	endtask

	task t_plain;
		w(16'h0345);
		chk({ev, ei, etr, ea}, {3'b101, 12'h745});
		w(16'h0080);
		chk(ea, 12'hF80);
		w(16'hFA08);
		chk({mwr, ev}, 2'b01);
	endtask

	task t_push;
		ext = 1'b1;
		w(16'h0025);
		chk({ei, etr, ea}, {2'b10, 12'h025});
		w(16'hFA08);
		chk({mwr, wd, addr, fp}, {1'b1, 8'h08, 12'h000, 12'hFFF});
		w(16'h0210);
		chk({mwr, ei, etr, ea}, {3'b011, 12'h00F});
		w(16'h0060);
		chk({ei, ea}, {1'b0, 12'h060});
	endtask

	task t_move;
		mv(16'hEB85, 16'hF006, {2'b11, 12'h004}, {2'b01, 8'h33, 12'h005});
		w(16'hE994);
		chk({fp, p0}, {12'hFEB, 12'h000});
		mv(16'hEB80, 16'hF00A, {2'b10, 12'hFEB}, {2'b01, 8'h00, 12'hFF5});
		mv(16'hEB8A, 16'hF001, {2'b11, 12'hFF5}, {2'b00, 8'h33, 12'hFEC});
	endtask

	task t_sub;
		w(16'hE905);
		chk(p0, 12'hFFB);
		w(16'hE945);
		chk(p1, 12'hFFB);
		w(16'hE9C5);
		chk({pc_low_byte, busy}, 2'b11);
		chk(pcv, 21'h12345);
		chk(fp, 12'hFE6);
		@(negedge clk);
		chk({pc_low_byte, busy}, 2'b00);
	endtask

	task finish_test;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_plain;
		t_push;
		t_move;
		t_sub;
		finish_test;
	end

	// Whole run is under a hundred cycles
	initial begin
		#20000;
		bad_count++;
		finish_test;
	end
endmodule // esx_exec_tb
`default_nettype wire
